/* File: core/ufc_params.svh */
// constants for the serial port flow control and dma request block
// assumes the includer wants plain macros, no processes
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH
`define UFC_FIFO_DEPTH 16
`define UFC_CNT_W 5
`define UFC_RX_CHAR_W 12
`define UFC_TX_CHAR_W 8
`define UFC_CR_CLEAR_FLOW_ENABLE_BIT 15
`define UFC_CR_REQUEST_FLOW_ENABLE_BIT 14
`define UFC_LVL_W 3
`define UFC_IFLS_RESET 6'h12
`endif

/* File: core/ufc_pkg.sv */
// types shared by the flow control and dma request block
// assumes the params header is on the include path
package ufc_pkg;
    typedef enum logic [2:0] {
        UFC_TX_IDLE = 3'b001,
        UFC_TX_SEND = 3'b010,
        UFC_TX_HALT = 3'b100
    } ufc_tx_state_e;
    typedef logic [4:0] ufc_cnt_t;
endpackage

/* File: core/ufc_sync.sv */
// two-flop synchroniser for a pin input
// assumes a single clock domain, asynchronous active-low reset
`timescale 1ns/1ps
module ufc_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    logic q_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RESET_VAL;
            q_reg <= RESET_VAL;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end
    assign q_o = q_reg;
endmodule

/* File: core/ufc_dma_req.sv */
// one dma request output with clear handshake
// assumes clear is synchronous to the same clock
`timescale 1ns/1ps
module ufc_dma_req (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic allow_i,
    input wire logic cond_i,
    input wire logic clear_i,
    output logic req_o
);
    logic req_reg;
    logic wait_reg;
    // wait for clear to drop before rearming
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_reg <= 1'b0;
        end else if (clear_i) begin
            wait_reg <= 1'b1;
        end else if (!clear_i) begin
            wait_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_reg <= 1'b0;
        end else if (!allow_i || clear_i) begin
            req_reg <= 1'b0;
        end else if (!req_reg && !wait_reg) begin
            req_reg <= cond_i;
        end
    end
    assign req_o = req_reg;
endmodule

/* File: core/ufc_flow_dma.sv */
// modem pins, hardware flow control and dma requests of a serial port
// assumes fifo counts, tx engine handshake and error interrupt come from
// logic on CLK_I; modem pins are asynchronous and synchronised here
//
// Notes on behaviour
// - terminal or communication role pin meaning
// - control bits 15, 14 enable gating
// - request-to-send asserted below rx watermark
// - request-to-send reasserts when fill drops
// - without rts control, receive until full
// - clear-to-send sampled before each character
// - clear drop: finish character, then halt
// - no cts control: send until empty
// - rx single request when fifo nonempty
// - rx burst request at or above watermark
// - tx single request when space exists
// - tx burst request at or below tx watermark
// - trigger points follow level selection
// - request holds until matching clear
// - single and burst requests independent
// - disable or dma enable off drops requests
// - no burst requests with fifos disabled
// - stop-on-error masks rx requests
// - all dma signals on bus clock
`timescale 1ns/1ps
`include "ufc_params.svh"
module ufc_flow_dma #(
    parameter int DEPTH = `UFC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // control bits
    input wire logic [15:0] PORT_CONTROL_REG_I,
    input wire logic PORT_ENABLE_I,
    input wire logic DCE_MODE_I,
    input wire logic FIFO_ENABLE_I,
    input wire logic [5:0] FIFO_LEVEL_SELECT_REG_I,
    input wire logic RX_DMA_ENABLE_I,
    input wire logic TX_DMA_ENABLE_I,
    input wire logic DMA_STOP_ON_ERROR_I,
    input wire logic RX_ERROR_INTERRUPT_I,
    // software modem outputs
    input wire logic SW_RTS_I,
    input wire logic SW_DTR_I,
    input wire logic SW_OUT1_I,
    input wire logic SW_OUT2_I,
    // fifo fill levels
    input wire logic [`UFC_CNT_W-1:0] RX_COUNT_I,
    input wire logic [`UFC_CNT_W-1:0] TX_COUNT_I,
    // transmit engine handshake and receive accept
    input wire logic TX_CHAR_DONE_I,
    output logic TX_START_O,
    output logic TX_BUSY_O,
    output logic RX_ACCEPT_O,
    // modem pins
    input wire logic CLEAR_TO_SEND_N_I,
    input wire logic DATA_SET_READY_N_I,
    input wire logic CARRIER_DETECT_N_I,
    input wire logic RING_INDICATOR_N_I,
    output logic REQUEST_TO_SEND_N_O,
    output logic TERMINAL_READY_N_O,
    output logic AUX_OUT_ONE_N_O,
    output logic AUX_OUT_TWO_N_O,
    // modem status seen by software, active high
    output logic [3:0] MODEM_STATUS_O,
    // dma
    input wire logic RX_REQUEST_CLEAR_I,
    input wire logic TX_REQUEST_CLEAR_I,
    output logic RX_SINGLE_REQUEST_O,
    output logic RX_BURST_REQUEST_O,
    output logic TX_SINGLE_REQUEST_O,
    output logic TX_BURST_REQUEST_O
);
    if (DEPTH != 16) begin : g_depth_check
        $error("ufc_flow_dma: trigger table serves a depth of 16 only");
    end

    ////////////////////////////////////////////////////////////////////////
    // level decode

    function automatic logic [`UFC_CNT_W-1:0] lvl_fill(input logic [2:0] sel);
        unique case (sel)
            3'h0: lvl_fill = 5'h02;
            3'h1: lvl_fill = 5'h04;
            3'h2: lvl_fill = 5'h08;
            3'h3: lvl_fill = 5'h0C;
            3'h4: lvl_fill = 5'h0E;
            default: lvl_fill = 5'h08;
        endcase
    endfunction

    logic [`UFC_CNT_W-1:0] rx_wm;
    logic [`UFC_CNT_W-1:0] tx_wm;
    logic [`UFC_CNT_W-1:0] tx_empty_cnt;
    logic cts_en;
    logic rts_en;
    assign rx_wm = lvl_fill(FIFO_LEVEL_SELECT_REG_I[5:3]);
    // tx trigger on empty locations: 14 empty means fill of 2 or less
    assign tx_wm = lvl_fill(FIFO_LEVEL_SELECT_REG_I[2:0]);
    assign tx_empty_cnt = 5'(DEPTH) - TX_COUNT_I;
    assign cts_en = PORT_CONTROL_REG_I[`UFC_CR_CLEAR_FLOW_ENABLE_BIT];
    assign rts_en = PORT_CONTROL_REG_I[`UFC_CR_REQUEST_FLOW_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic cts_n_s;
    logic dsr_n_s;
    logic dcd_n_s;
    logic ri_n_s;
    ufc_sync u_sync_cts (.clk_i(CLK_I), .rst_n_i(RST_N_I), .d_i(CLEAR_TO_SEND_N_I),
        .q_o(cts_n_s));
    ufc_sync u_sync_dsr (.clk_i(CLK_I), .rst_n_i(RST_N_I), .d_i(DATA_SET_READY_N_I),
        .q_o(dsr_n_s));
    ufc_sync u_sync_dcd (.clk_i(CLK_I), .rst_n_i(RST_N_I), .d_i(CARRIER_DETECT_N_I),
        .q_o(dcd_n_s));
    ufc_sync u_sync_ri (.clk_i(CLK_I), .rst_n_i(RST_N_I), .d_i(RING_INDICATOR_N_I),
        .q_o(ri_n_s));

    ////////////////////////////////////////////////////////////////////////
    // modem roles

    logic [3:0] modem_status_reg;
    logic dtr_n_reg;
    logic out1_n_reg;
    logic out2_n_reg;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            modem_status_reg <= 4'h0;
            dtr_n_reg <= 1'b1;
            out1_n_reg <= 1'b1;
            out2_n_reg <= 1'b1;
        end else begin
            // bits: 0 cts/rts, 1 dsr/dtr, 2 dcd, 3 ri
            modem_status_reg <= {~ri_n_s & ~DCE_MODE_I, ~dcd_n_s & ~DCE_MODE_I,
                ~dsr_n_s, ~cts_n_s};
            dtr_n_reg <= ~SW_DTR_I;
            out1_n_reg <= ~SW_OUT1_I;
            out2_n_reg <= ~SW_OUT2_I;
        end
    end
    assign MODEM_STATUS_O = modem_status_reg;
    assign TERMINAL_READY_N_O = dtr_n_reg;
    assign AUX_OUT_ONE_N_O = out1_n_reg;
    assign AUX_OUT_TWO_N_O = out2_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // rts flow control

    logic rts_n_reg;
    logic rx_full;
    assign rx_full = (RX_COUNT_I >= (FIFO_ENABLE_I ? 5'(DEPTH) : 5'h01));
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rts_n_reg <= 1'b1;
        end else if (rts_en) begin
            rts_n_reg <= ~(RX_COUNT_I < rx_wm);
        end else begin
            rts_n_reg <= ~SW_RTS_I;
        end
    end
    assign REQUEST_TO_SEND_N_O = rts_n_reg;
    assign RX_ACCEPT_O = PORT_ENABLE_I && !rx_full;

    ////////////////////////////////////////////////////////////////////////
    // cts gating of the transmitter

    ufc_pkg::ufc_tx_state_e tx_state_reg;
    ufc_pkg::ufc_tx_state_e tx_state_next;
    logic tx_go;
    assign tx_go = PORT_ENABLE_I && (TX_COUNT_I != 5'h00) && (!cts_en || !cts_n_s);
    always_comb begin
        tx_state_next = tx_state_reg;
        unique case (tx_state_reg)
            ufc_pkg::UFC_TX_IDLE: begin
                if (tx_go) begin
                    tx_state_next = ufc_pkg::UFC_TX_SEND;
                end
            end
            ufc_pkg::UFC_TX_SEND: begin
                if (TX_CHAR_DONE_I) begin
                    tx_state_next = (cts_en && cts_n_s) ? ufc_pkg::UFC_TX_HALT
                        : ufc_pkg::UFC_TX_IDLE;
                end
            end
            ufc_pkg::UFC_TX_HALT: begin
                if (!cts_en || !cts_n_s) begin
                    tx_state_next = ufc_pkg::UFC_TX_IDLE;
                end
            end
            default: tx_state_next = ufc_pkg::UFC_TX_IDLE;
        endcase
    end
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tx_state_reg <= ufc_pkg::UFC_TX_IDLE;
        end else begin
            tx_state_reg <= tx_state_next;
        end
    end
    assign TX_START_O = (tx_state_reg == ufc_pkg::UFC_TX_IDLE) && tx_go;
    assign TX_BUSY_O = (tx_state_reg == ufc_pkg::UFC_TX_SEND);

    ////////////////////////////////////////////////////////////////////////
    // dma requests

    logic rx_allow;
    logic tx_allow;
    logic rx_single_cond;
    logic rx_burst_cond;
    logic tx_single_cond;
    logic tx_burst_cond;
    assign rx_allow = PORT_ENABLE_I && RX_DMA_ENABLE_I
        && !(DMA_STOP_ON_ERROR_I && RX_ERROR_INTERRUPT_I);
    assign tx_allow = PORT_ENABLE_I && TX_DMA_ENABLE_I;
    assign rx_single_cond = (RX_COUNT_I != 5'h00);
    assign rx_burst_cond = FIFO_ENABLE_I && (RX_COUNT_I >= rx_wm);
    assign tx_single_cond = (TX_COUNT_I < (FIFO_ENABLE_I ? 5'(DEPTH) : 5'h01));
    assign tx_burst_cond = FIFO_ENABLE_I && (tx_empty_cnt >= 5'(DEPTH) - tx_wm);

    ufc_dma_req u_rx_single (.clk_i(CLK_I), .rst_n_i(RST_N_I), .allow_i(rx_allow),
        .cond_i(rx_single_cond), .clear_i(RX_REQUEST_CLEAR_I), .req_o(RX_SINGLE_REQUEST_O));
    ufc_dma_req u_rx_burst (.clk_i(CLK_I), .rst_n_i(RST_N_I),
        .allow_i(rx_allow && FIFO_ENABLE_I), .cond_i(rx_burst_cond),
        .clear_i(RX_REQUEST_CLEAR_I), .req_o(RX_BURST_REQUEST_O));
    ufc_dma_req u_tx_single (.clk_i(CLK_I), .rst_n_i(RST_N_I), .allow_i(tx_allow),
        .cond_i(tx_single_cond), .clear_i(TX_REQUEST_CLEAR_I), .req_o(TX_SINGLE_REQUEST_O));
    ufc_dma_req u_tx_burst (.clk_i(CLK_I), .rst_n_i(RST_N_I),
        .allow_i(tx_allow && FIFO_ENABLE_I), .cond_i(tx_burst_cond),
        .clear_i(TX_REQUEST_CLEAR_I), .req_o(TX_BURST_REQUEST_O));

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_clear_seen;
        RX_REQUEST_CLEAR_I;
    endsequence
    property p_rts_level;
        @(posedge CLK_I) disable iff (!RST_N_I)
        rts_en |=> (REQUEST_TO_SEND_N_O == !($past(RX_COUNT_I) < $past(rx_wm)));
    endproperty
    a_rts_level: assert property (p_rts_level) else $error("rts level wrong");
    property p_rts_back;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (rts_en && REQUEST_TO_SEND_N_O && RX_COUNT_I < rx_wm) |=> !REQUEST_TO_SEND_N_O;
    endproperty
    a_rts_back: assert property (p_rts_back) else $error("rts not reasserted");
    property p_cts_gate;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (TX_START_O && cts_en) |-> !$past(CLEAR_TO_SEND_N_I, 2);
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("start while cts off");
    property p_cts_halt;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (TX_BUSY_O && TX_CHAR_DONE_I && cts_en && cts_n_s) |=> !TX_START_O;
    endproperty
    a_cts_halt: assert property (p_cts_halt) else $error("no halt after char");
    property p_clear_drops;
        @(posedge CLK_I) disable iff (!RST_N_I)
        s_clear_seen |=> !RX_SINGLE_REQUEST_O && !RX_BURST_REQUEST_O;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("rx req after clear");
    property p_disable_drops;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !PORT_ENABLE_I |=> !TX_SINGLE_REQUEST_O && !TX_BURST_REQUEST_O;
    endproperty
    a_disable_drops: assert property (p_disable_drops) else $error("req while off");
    property p_no_burst;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !FIFO_ENABLE_I |=> !RX_BURST_REQUEST_O && !TX_BURST_REQUEST_O;
    endproperty
    a_no_burst: assert property (p_no_burst) else $error("burst without fifo");
    property p_err_mask;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (DMA_STOP_ON_ERROR_I && RX_ERROR_INTERRUPT_I) |=> !RX_SINGLE_REQUEST_O
            && !RX_BURST_REQUEST_O;
    endproperty
    a_err_mask: assert property (p_err_mask) else $error("rx req during error");
    property p_rx_single;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (rx_allow && rx_single_cond && !RX_REQUEST_CLEAR_I && !RX_SINGLE_REQUEST_O)
            [*2] |=> RX_SINGLE_REQUEST_O;
    endproperty
    a_rx_single: assert property (p_rx_single) else $error("rx single missing");
endmodule

/* File: verification/ufc_far_end.sv */
// far side model: dma controller that clears requests, remote transmitter
// assumes requests and the rts pin are registered on the bus clock
`timescale 1ns/1ps
module ufc_far_end (
    // clock, reset, pacing
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] delay_i,
    // from the block
    input wire logic rx_req_i,
    input wire logic tx_req_i,
    input wire logic rts_n_i,
    // to the block
    output logic rx_clear_o,
    output logic tx_clear_o,
    output logic rx_push_o
);
    logic [2:0] rx_wait_reg, tx_wait_reg, bit_reg;
    ////////////////////////////////////////
    // clear on the last item
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {rx_clear_o, tx_clear_o, rx_wait_reg, tx_wait_reg} <= 8'h00;
        end else begin
            rx_clear_o <= rx_req_i && !rx_clear_o && rx_wait_reg == delay_i;
            tx_clear_o <= tx_req_i && !tx_clear_o && tx_wait_reg == delay_i;
            rx_wait_reg <= (rx_req_i && !rx_clear_o) ? rx_wait_reg + 3'h1 : 3'h0;
            tx_wait_reg <= (tx_req_i && !tx_clear_o) ? tx_wait_reg + 3'h1 : 3'h0;
        end
    end
    ////////////////////////////////////////
    // start only while rts asserted
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {bit_reg, rx_push_o} <= 4'h0;
        end else begin
            rx_push_o <= bit_reg == 3'h7;
            bit_reg <= (bit_reg != 3'h0 || !rts_n_i) ? bit_reg + 3'h1 : 3'h0;
        end
    end
endmodule

/* File: verification/ufc_flow_dma_tb.sv */
// bench: drives the flow control block, models it, compares each cycle
// assumes the design files and the far side model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module ufc_flow_dma_tb;
    logic clk = 0, rst_n = 0, pen = 0, dce = 0, fen = 1, rxde = 0, txde = 0;
    logic soe = 0, rxerr = 0, done = 0, stream = 0;
    logic [15:0] pcr = 16'h0000;
    logic [5:0] fls = 6'h12;
    logic [3:0] sw = 4'h0, pins_n = 4'hF, m_req, m_wait, m_allow, m_cond, mst;
    logic [4:0] rxc = 5'h00, txc = 5'h00;
    logic rclr, tclr, push, tstart, tbusy, racc, rts_n, dtr_n, o1_n, o2_n, m_rts_n;
    logic rsr, rbr, tsr, tbr;
    logic [2:0] dly = 3'h1;
    logic [31:0] rnd = 32'h047672B4;
    int n_mismatch = 0, comparisons = 0, n_start = 0, n_busy = 0, bcnt = 0;
    int lim, lm, rxl, txl;
    int lv [8] = '{2, 4, 8, 12, 14, 8, 8, 8};
    initial forever #5 clk = ~clk;
    ufc_flow_dma ufc_flow_dma_inst (.CLK_I(clk), .RST_N_I(rst_n), .PORT_CONTROL_REG_I(pcr),
        .PORT_ENABLE_I(pen), .DCE_MODE_I(dce), .FIFO_ENABLE_I(fen),
        .FIFO_LEVEL_SELECT_REG_I(fls), .RX_DMA_ENABLE_I(rxde), .TX_DMA_ENABLE_I(txde),
        .DMA_STOP_ON_ERROR_I(soe), .RX_ERROR_INTERRUPT_I(rxerr), .SW_RTS_I(sw[0]),
        .SW_DTR_I(sw[1]), .SW_OUT1_I(sw[2]), .SW_OUT2_I(sw[3]), .RX_COUNT_I(rxc),
        .TX_COUNT_I(txc), .TX_CHAR_DONE_I(done), .TX_START_O(tstart), .TX_BUSY_O(tbusy),
        .RX_ACCEPT_O(racc), .CLEAR_TO_SEND_N_I(pins_n[0]), .DATA_SET_READY_N_I(pins_n[1]),
        .CARRIER_DETECT_N_I(pins_n[2]), .RING_INDICATOR_N_I(pins_n[3]),
        .REQUEST_TO_SEND_N_O(rts_n), .TERMINAL_READY_N_O(dtr_n), .AUX_OUT_ONE_N_O(o1_n),
        .AUX_OUT_TWO_N_O(o2_n), .MODEM_STATUS_O(mst), .RX_REQUEST_CLEAR_I(rclr),
        .TX_REQUEST_CLEAR_I(tclr), .RX_SINGLE_REQUEST_O(rsr), .RX_BURST_REQUEST_O(rbr),
        .TX_SINGLE_REQUEST_O(tsr), .TX_BURST_REQUEST_O(tbr));
    ufc_far_end ufc_far_end_inst (.clk_i(clk), .rst_n_i(rst_n), .delay_i(dly),
        .rx_req_i(rsr | rbr), .tx_req_i(tsr | tbr), .rts_n_i(rts_n),
        .rx_clear_o(rclr), .tx_clear_o(tclr), .rx_push_o(push));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always_comb begin
        rxl = lv[fls[5:3]];
        txl = lv[fls[2:0]];
        lim = fen ? 16 : 1;
        m_cond = {txc <= txl, txc < lim, rxc >= rxl, rxc >= 1};
        m_allow[0] = pen && rxde && !(soe && rxerr);
        m_allow[1] = m_allow[0] && fen;
        m_allow[2] = pen && txde;
        m_allow[3] = m_allow[2] && fen;
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {m_req, m_wait, m_rts_n} = 9'h001;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (k < 2 ? rclr : tclr) {m_req[k], m_wait[k]} = 2'b01;
                else if (!m_allow[k]) {m_req[k], m_wait[k]} = 2'b00;
                else if (m_wait[k]) m_wait[k] = 1'b0;
                else if (m_cond[k]) m_req[k] = 1'b1;
            end
            m_rts_n = pcr[14] ? rxc >= rxl : !sw[0];
        end
    end
    task automatic cyc();
        @(negedge clk);
        `CHK("rx_requests", m_req[1:0], {rbr, rsr})
        `CHK("tx_requests", m_req[3:2], {tbr, tsr})
        `CHK("rts_pin", m_rts_n, rts_n)
        `CHK("rx_accept", pen && rxc < lim, racc)
        n_start += tstart;
        n_busy += tbusy;
        bcnt = tbusy ? bcnt + 1 : 0;
        done = bcnt == 4;
        if (stream && push && rxc < 16) rxc = rxc + 5'h01;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        `CHK("reset_pins", 4'hF, {rts_n, dtr_n, o1_n, o2_n})
        @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            {dce, sw, pins_n} = rnd[8:0];
            repeat (4) cyc();
            `CHK("status", dce ? {2'b00, ~pins_n[1:0]} : ~pins_n, mst)
            `CHK("outputs", ~sw[3:1], {o2_n, o1_n, dtr_n})
        end
        {dce, pen, pcr, txc, pins_n, n_start} = {2'b01, 16'h8000, 5'h03, 4'hF, 32'd0};
        repeat (20) cyc();
        `CHK("tx_blocked", 0, n_start)
        pins_n[0] = 1'b0;
        for (int k = 0; k < 20 && tbusy !== 1'b1; k++) cyc();
        {pins_n[0], n_busy} = {1'b1, 32'd0};
        repeat (30) cyc();
        `CHK("tx_finish", 3, n_busy)
        `CHK("tx_halted", 1, n_start)
        {pcr, n_start} = {16'h0000, 32'd0};
        repeat (30) cyc();
        `CHK("tx_ungated", 1'b1, n_start >= 4)
        txc = 5'h00;
        repeat (8) cyc();
        n_start = 0;
        repeat (20) cyc();
        `CHK("tx_empty_idle", 0, n_start)
        {pcr, fls, rxc, stream} = {16'h4000, 6'h08, 5'h00, 1'b1};
        repeat (150) cyc();
        `CHK("rx_paused", 1'b1, rxc >= 4 && rxc <= 5)
        rxc = 5'h03;
        repeat (150) cyc();
        {pcr[14], sw[0]} = 2'b01;
        repeat (200) cyc();
        `CHK("rx_full", 5'h10, rxc)
        stream = 1'b0;
        for (int i = 0; i < 4000; i++) begin
            cyc();
            rnd = lfsr(rnd);
            if (m_req == 4'h0 && m_wait == 4'h0 && !rclr && !tclr && rnd[3:0] == 4'h0) begin
                {pcr[15:14], pen, fen, fls, rxde, txde, soe, rxerr, sw[0]} = rnd[18:4];
                {fen, pen} = {fen | pcr[14], pen | rnd[19]};
                {rxde, txde} = {rxde | rnd[20], txde | rnd[21]};
                dly = rnd[24:22] | 3'h1;
            end
            rnd = lfsr(rnd);
            lm = fen ? 17 : 2;
            rxc = rnd[31] ? 5'h00 : 5'(rnd[4:0] % lm);
            txc = rnd[31] ? 5'(lm - 1) : 5'(rnd[9:5] % lm);
        end
        end_of_test();
    end
endmodule
